// >>> common/ocp_timer_pkg.sv
package ocp_timer_pkg;

  localparam int CLK_NS      = 4;
  localparam int TICK_US     = 10;
  localparam int TICK_CYC    = TICK_US * 1000 / CLK_NS;
  localparam int CHANNELS    = 4;
  localparam int OC_STEPS    = 7;
  localparam int CB_STEPS    = 6;
  localparam int TMR_W       = 20;

  // step tables in microseconds (over-current) and milliseconds (cooling)
  localparam int OC_STEP_US [4][7] = '{
    '{5000, 1720, 2000, 3000, 5000, 12200, 44600},
    '{2480, 800, 1040, 1580, 2240, 6120, 22200},
    '{9800, 3200, 4200, 5800, 9800, 24400, 89200},
    '{19600, 6400, 8400, 11600, 19600, 48800, 178400}};
  localparam int CB_STEP_MS [3][6] = '{
    '{834, 448, 510, 596, 718, 898},
    '{418, 224, 254, 290, 360, 648},
    '{1668, 894, 1022, 1192, 1434, 1796}};
  localparam logic [1:0] OC_SEL_RESET = 2'h0;

  localparam real BLANK_US    = 5.0;
  localparam real SHUT_US     = 7.0;
  localparam int  BLANK_CYC   = int'($ceil(BLANK_US * 1000.0 / CLK_NS));
  localparam int  SHUT_CYC    = int'($ceil(SHUT_US * 1000.0 / CLK_NS));
  localparam logic [10:0] BLANK_LAST = 11'(BLANK_CYC - 1);
  localparam logic [10:0] SHUT_LAST  = 11'(SHUT_CYC - 1);
  localparam int  WDOG_MS     = 310;
  localparam int  WDOG_TICKS  = WDOG_MS * 1000 / TICK_US;
  localparam int  OL_DIV      = 128;

  typedef struct packed {
    logic [3:0] overtemp;
    logic [3:0] short_circuit;
    logic [3:0] overcurrent;
    logic       undervoltage;
  } fault_in_t;

  typedef struct packed {
    logic [2:0]       oc_step;
    logic [TMR_W-1:0] oc_tmr;
    logic             oc_run;
    logic [2:0]       cooled;
    logic [TMR_W-1:0] cb_tmr;
    logic [10:0]      blank_cnt;
    logic             flagged;
    logic [10:0]      sd_cnt;
    logic             shut;
  } chan_t;

endpackage : ocp_timer_pkg

// >>> src/overcurrent_profile_timer.sv
`timescale 1ns/1ns
`default_nettype none
module overcurrent_profile_timer
  import ocp_timer_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int WDOG_LEN    = WDOG_TICKS
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [1:0]       overcurrent_profile_sel,
  input  wire logic [1:0]       cooling_profile_sel,
  input  wire logic [3:0]       channel_cmd,
  input  wire logic [3:0]       direct_input,
  input  wire logic [3:0]       led_mode,
  input  wire fault_in_t        faults,
  input  wire logic             failsafe_input,
  input  wire logic             watchdog_refresh,
  input  wire logic             pwm_clock_input,
  output logic [3:0]            high_side_output,
  output logic                  fault_flag_n,
  output logic [3:0][2:0]       oc_step_index,
  output logic [3:0]            openload_check,
  output logic                  failsafe_active
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (TICK_CYCLES < 2 || TICK_CYCLES > 4095) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end
  if (WDOG_LEN < 2 || WDOG_LEN > 32767) begin : g_bad_wdog
    $error("WDOG_LEN out of range");
  end

  typedef struct packed {
    chan_t [3:0] ch;
    logic [11:0] pre;
    logic [14:0] wd_cnt;
    logic        failsafe;
    logic        pwm_q;
    logic [6:0]  ol_cnt;
    logic [3:0]  ol;
    logic [3:0]  hs;
  } state_t;

  state_t s_ff;
  state_t nxt_s;
  logic   tick;
  logic   pwm_edge;
  logic [3:0] fault_now;

  // step lengths in ticks of the shared base
  function automatic logic [TMR_W-1:0] oc_ticks(input logic [1:0] sel,
                                                 input logic [2:0] st);
    oc_ticks = TMR_W'(OC_STEP_US[sel][st] / TICK_US);
  endfunction : oc_ticks

  // codes 00 and 11 share the medium row
  function automatic logic [TMR_W-1:0] cb_ticks(input logic [1:0] sel,
                                                input logic [2:0] st);
    int row;
    row = (sel == 2'h1) ? 1 : (sel == 2'h2) ? 2 : 0;
    cb_ticks = TMR_W'(CB_STEP_MS[row][st] * 1000 / TICK_US);
  endfunction : cb_ticks

  ////////////////////////////////////////////////////////////////////////////
  // shared time base: every step timer advances on this one tick
  assign tick     = (s_ff.pre == 12'(TICK_CYCLES - 1));
  assign pwm_edge = pwm_clock_input & ~s_ff.pwm_q;

  // any listed fault counts; over-current only matters while driven
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      fault_now[c] = faults.overtemp[c] | faults.short_circuit[c] |
                     faults.undervoltage |
                     (faults.overcurrent[c] & s_ff.hs[c]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    nxt_s       = s_ff;
    nxt_s.pre   = tick ? 12'h000 : s_ff.pre + 12'h001;
    nxt_s.pwm_q = pwm_clock_input;
    nxt_s.ol    = 4'h0;

    // open-load check pulse every 128 pwm clock periods
    if (pwm_edge) begin
      nxt_s.ol_cnt = s_ff.ol_cnt + 7'h01;
      if (s_ff.ol_cnt == 7'(OL_DIV - 1)) begin
        nxt_s.ol = led_mode & s_ff.hs;
      end
    end

    // watchdog runs only with fail-safe input open; expiry is sticky
    if (failsafe_input && !s_ff.failsafe) begin
      if (watchdog_refresh) begin
        nxt_s.wd_cnt = 15'h0000;
      end else if (tick) begin
        if (s_ff.wd_cnt == 15'(WDOG_LEN - 1)) begin
          nxt_s.failsafe = 1'b1;
        end else begin
          nxt_s.wd_cnt = s_ff.wd_cnt + 15'h0001;
        end
      end
    end

    for (int c = 0; c < CHANNELS; c++) begin
      // blanking before the flag; a fault that vanishes restarts it
      if (!s_ff.ch[c].flagged) begin
        if (!fault_now[c]) begin
          nxt_s.ch[c].blank_cnt = 11'h000;
        end else if (s_ff.ch[c].blank_cnt == BLANK_LAST) begin
          nxt_s.ch[c].flagged = 1'b1;
        end else begin
          nxt_s.ch[c].blank_cnt = s_ff.ch[c].blank_cnt + 11'h001;
        end
      end else if (!s_ff.ch[c].shut) begin
        if (s_ff.ch[c].sd_cnt == SHUT_LAST) begin
          nxt_s.ch[c].shut = 1'b1;
        end else begin
          nxt_s.ch[c].sd_cnt = s_ff.ch[c].sd_cnt + 11'h001;
        end
      end
      // release needs command off and no fault, so a new fault wins
      if (!channel_cmd[c] && !fault_now[c]) begin
        nxt_s.ch[c].flagged   = 1'b0;
        nxt_s.ch[c].shut      = 1'b0;
        nxt_s.ch[c].blank_cnt = 11'h000;
        nxt_s.ch[c].sd_cnt    = 11'h000;
      end

      // drive: fail-safe hands channels 0 and 2 to their direct inputs
      if (s_ff.failsafe) begin
        nxt_s.hs[c] = (c == 0 || c == 2) ? direct_input[c] : 1'b0;
      end else begin
        nxt_s.hs[c] = channel_cmd[c] & ~s_ff.ch[c].shut;
      end

      // over-current profile: a still-warm lamp starts at a later step
      if (!s_ff.hs[c]) begin
        nxt_s.ch[c].oc_run = 1'b0;
        if (nxt_s.hs[c]) begin
          nxt_s.ch[c].oc_step = 3'(CB_STEPS) - s_ff.ch[c].cooled;
          nxt_s.ch[c].oc_tmr  = '0;
          nxt_s.ch[c].oc_run  = 1'b1;
        end
      end else if (s_ff.ch[c].oc_run && tick) begin
        if (s_ff.ch[c].oc_tmr ==
            oc_ticks(overcurrent_profile_sel, s_ff.ch[c].oc_step) - 1'b1) begin
          nxt_s.ch[c].oc_tmr  = '0;
          nxt_s.ch[c].oc_step = s_ff.ch[c].oc_step + 3'h1;
          if (s_ff.ch[c].oc_step == 3'(OC_STEPS - 1)) begin
            nxt_s.ch[c].oc_run = 1'b0;
          end
        end else begin
          nxt_s.ch[c].oc_tmr = s_ff.ch[c].oc_tmr + 1'b1;
        end
      end

      // bulb cooling: steps elapse only while the output is off
      if (s_ff.hs[c]) begin
        nxt_s.ch[c].cooled = 3'h0;
        nxt_s.ch[c].cb_tmr = '0;
      end else if (s_ff.ch[c].cooled != 3'(CB_STEPS) && tick) begin
        if (s_ff.ch[c].cb_tmr ==
            cb_ticks(cooling_profile_sel, s_ff.ch[c].cooled) - 1'b1) begin
          nxt_s.ch[c].cb_tmr = '0;
          nxt_s.ch[c].cooled = s_ff.ch[c].cooled + 3'h1;
        end else begin
          nxt_s.ch[c].cb_tmr = s_ff.ch[c].cb_tmr + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; lamps start fully cooled, step index parked at 7
  always_ff @(posedge clock) begin
    if (rst) begin
      nxt_s_reset : begin
        s_ff <= '0;
        for (int c = 0; c < CHANNELS; c++) begin
          s_ff.ch[c].cooled  <= 3'(CB_STEPS);
          s_ff.ch[c].oc_step <= 3'(OC_STEPS);
        end
      end
    end else begin
      s_ff <= nxt_s;
    end
  end

  // outputs from flops; fault_flag_n is combined from all channel flags
  assign high_side_output = s_ff.hs;
  assign openload_check   = s_ff.ol;
  assign failsafe_active  = s_ff.failsafe;
  always_comb begin
    fault_flag_n = 1'b1;
    for (int c = 0; c < CHANNELS; c++) begin
      oc_step_index[c] = s_ff.ch[c].oc_step;
      fault_flag_n     = fault_flag_n & ~s_ff.ch[c].flagged;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb_main @(posedge clock); endclocking
  default disable iff (rst);

  for (genvar g = 0; g < CHANNELS; g++) begin : g_chk
    chk_flag_blank : assert property (
      $rose(s_ff.ch[g].flagged) |->
        $past(s_ff.ch[g].blank_cnt) == BLANK_LAST && $past(fault_now[g]))
      else $error("flag raised without full blanking");
    chk_flag_pin : assert property (
      s_ff.ch[g].flagged |-> !fault_flag_n)
      else $error("fault flag not low");
    chk_shut_delay : assert property (
      $rose(s_ff.ch[g].shut) |->
        $past(s_ff.ch[g].flagged) && $past(s_ff.ch[g].sd_cnt) == SHUT_LAST)
      else $error("shutdown delay wrong");
    chk_shut_output : assert property (
      s_ff.ch[g].shut && !s_ff.failsafe |=> !high_side_output[g])
      else $error("faulted output still on");
    chk_oc_start : assert property (
      $rose(s_ff.ch[g].oc_run) |->
        s_ff.ch[g].oc_step == 3'(CB_STEPS) - $past(s_ff.ch[g].cooled))
      else $error("profile start step wrong");
    chk_oc_step_len : assert property (
      s_ff.ch[g].oc_run && $past(s_ff.ch[g].oc_run) &&
      s_ff.ch[g].oc_step != $past(s_ff.ch[g].oc_step) |->
        $past(s_ff.ch[g].oc_tmr) ==
        oc_ticks($past(overcurrent_profile_sel),
                 $past(s_ff.ch[g].oc_step)) - 1'b1)
      else $error("over-current step length wrong");
    chk_cool_len : assert property (
      s_ff.ch[g].cooled == $past(s_ff.ch[g].cooled) + 3'h1 |->
        $past(s_ff.ch[g].cb_tmr) ==
        cb_ticks($past(cooling_profile_sel), $past(s_ff.ch[g].cooled)) - 1'b1)
      else $error("cooling step length wrong");
  end

  chk_wdog_expire : assert property (
    $rose(s_ff.failsafe) |->
      $past(s_ff.wd_cnt) == 15'(WDOG_LEN - 1) && $past(failsafe_input))
    else $error("watchdog expired early");
  chk_failsafe_follow : assert property (
    s_ff.failsafe |=> high_side_output[0] == $past(direct_input[0]) &&
      high_side_output[2] == $past(direct_input[2]) &&
      !high_side_output[1] && !high_side_output[3])
    else $error("fail-safe outputs wrong");
  chk_openload_period : assert property (
    openload_check != 4'h0 |->
      $past(pwm_edge) && $past(s_ff.ol_cnt) == 7'(OL_DIV - 1))
    else $error("open-load check off period");

endmodule : overcurrent_profile_timer
`default_nettype wire

// >>> verif/lamp_load.sv
`timescale 1ns/1ns
`default_nettype none
// lamp and led loads on the high-side outputs, plus the pwm clock source
module lamp_load (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [3:0] high_side_output,
  input  wire logic [3:0] overload_req,
  input  wire logic       pwm_run,
  output var  logic [3:0] overcurrent,
  output var  logic       pwm_clock_input
);
  logic [1:0] div_ff;
  ////////////////////////////////////////////////////////////////////////////
  // an undriven lamp draws nothing, so overload shows only while driven
  always_ff @(posedge clock) begin
    if (rst) begin
      overcurrent <= 4'h0;
    end else begin
      overcurrent <= high_side_output & overload_req;
    end
  end
  // pwm clock stands low when stopped, period 8 cycles when running
  always_ff @(posedge clock) begin
    if (rst || !pwm_run) begin
      div_ff          <= 2'h0;
      pwm_clock_input <= 1'b0;
    end else begin
      div_ff <= div_ff + 2'h1;
      if (div_ff == 2'h3) begin
        pwm_clock_input <= ~pwm_clock_input;
      end
    end
  end
endmodule : lamp_load
`default_nettype wire

// >>> verif/overcurrent_profile_timer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module overcurrent_profile_timer_tb_top
  import ocp_timer_pkg::*;
;
  localparam int TK = 2;
  logic clock = 1'b0, rst = 1'b1, fs_in = 1'b0, refresh = 1'b0;
  logic pwm_run = 1'b0, uv = 1'b0, pwm, flag_n, fs_act;
  logic [1:0] oc_sel = OC_SEL_RESET, cb_sel = 2'h0;
  logic [3:0] cmd = 4'h0, direct = 4'h0, led = 4'h0, ot = 4'h0;
  logic [3:0] sc = 4'h0, ol_req = 4'h0, oc_w, hs, olc;
  logic [3:0][2:0] step;
  fault_in_t flt;
  int bad_count = 0;
  int tests_run = 0;
  assign flt = {ot, sc, oc_w, uv};
  always #2 clock = ~clock;
  overcurrent_profile_timer #(.TICK_CYCLES(TK), .WDOG_LEN(5)) dut (
    .clock(clock), .rst(rst), .overcurrent_profile_sel(oc_sel),
    .cooling_profile_sel(cb_sel), .channel_cmd(cmd), .direct_input(direct),
    .led_mode(led), .faults(flt), .failsafe_input(fs_in),
    .watchdog_refresh(refresh), .pwm_clock_input(pwm),
    .high_side_output(hs), .fault_flag_n(flag_n), .oc_step_index(step),
    .openload_check(olc), .failsafe_active(fs_act));
  lamp_load load (.clock(clock), .rst(rst), .high_side_output(hs),
    .overload_req(ol_req), .pwm_run(pwm_run), .overcurrent(oc_w),
    .pwm_clock_input(pwm));
  //////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic check(input bit ok, input string msg);
    tests_run++;
    if (!ok) begin
      bad_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task automatic do_reset;
    cmd <= 4'h0;
    led <= 4'h0;
    rst <= 1'b1;
    cyc(6);
    rst <= 1'b0;
    cyc(1);
  endtask : do_reset
  task automatic finish_test;
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  //////////////////////////////////////////////////////////////////////////
  // scenarios; a fresh reset gives every channel a fully cooled lamp
  task automatic profile(input int ch, input logic [1:0] sel, input int n);
    int c, d;
    oc_sel <= sel;
    do_reset();
    cmd[ch] <= 1'b1;
    for (int k = 0; k < n; k++) begin
      c = 0;
      while (step[ch] !== 3'(k) && c < 100) begin
        cyc(1);
        c++;
      end
      c = 0;
      while (step[ch] === 3'(k) && c < 200000) begin
        cyc(1);
        c++;
      end
      // tick phase can shift each edge by up to one tick
      d = c - OC_STEP_US[sel][k] / TICK_US * TK;
      check(d >= -4 && d <= 4, "step length off");
    end
  endtask : profile
  task automatic set_fault(input int kind, input logic on);
    case (kind)
      0: ot <= on ? 4'h2 : 4'h0;
      1: sc <= on ? 4'h2 : 4'h0;
      2: ol_req <= on ? 4'h2 : 4'h0;
      default: uv <= on;
    endcase
  endtask : set_fault
  task automatic fault_case(input int kind);
    int c;
    do_reset();
    cmd <= 4'hF;
    cyc(4);
    set_fault(kind, 1'b1);
    cyc(1000);
    set_fault(kind, 1'b0);
    cyc(10);
    check(flag_n === 1'b1, "flag raised by short fault");
    set_fault(kind, 1'b1);
    c = 0;
    while (flag_n !== 1'b0 && c < 3000) begin
      cyc(1);
      c++;
    end
    check(c >= 1247 && c <= 1256, "blanking time");
    check(hs === 4'hF, "output dropped before delay");
    c = 0;
    while (hs[1] !== 1'b0 && c < 3000) begin
      cyc(1);
      c++;
    end
    check(c >= 1746 && c <= 1756, "shutdown delay");
    check(hs === (kind == 3 ? 4'h0 : 4'hD), "wrong channels off");
    cmd <= 4'h0;
    set_fault(kind, 1'b0);
    cyc(4);
    check(flag_n === 1'b1, "flag not released");
  endtask : fault_case
  task automatic wdog;
    fs_in <= 1'b0;
    do_reset();
    cmd <= 4'hF;
    cyc(40);
    check(fs_act === 1'b0 && hs === 4'hF, "watchdog while off");
    fs_in <= 1'b1;
    do_reset();
    repeat (10) begin
      refresh <= 1'b1;
      cyc(1);
      refresh <= 1'b0;
      cyc(3);
    end
    check(fs_act === 1'b0, "refresh ignored");
    cyc(6);
    check(fs_act === 1'b0, "watchdog expired early");
    cyc(6);
    check(fs_act === 1'b1, "no fail-safe on expiry");
    cmd <= 4'h0;
    direct <= 4'hF;
    cyc(3);
    check(hs === 4'h5, "fail-safe outputs 0 and 2");
    direct <= 4'hA;
    cyc(3);
    check(hs === 4'h0, "fail-safe outputs 1 and 3");
    // without refresh the timeout runs from the release of reset
    do_reset();
    cyc(8);
    check(fs_act === 1'b0, "timeout short of reset release");
    cyc(2);
    check(fs_act === 1'b1, "timeout late after reset release");
    fs_in <= 1'b0;
  endtask : wdog
  task automatic openload;
    int c;
    do_reset();
    led <= 4'h5;
    cmd <= 4'hF;
    pwm_run <= 1'b1;
    c = 0;
    while (olc === 4'h0 && c < 1500) begin
      cyc(1);
      c++;
    end
    check(olc === 4'h5, "open-load channel mask");
    cyc(1);
    check(olc === 4'h0, "open-load pulse too long");
    c = 1;
    while (olc === 4'h0 && c < 1500) begin
      cyc(1);
      c++;
    end
    check(c == 1024, "open-load period");
    pwm_run <= 1'b0;
  endtask : openload
  task automatic reset_state;
    do_reset();
    check(flag_n === 1'b1 && hs === 4'h0, "reset outputs");
    check(step === {4{3'h7}}, "reset step index");
  endtask : reset_state
  // default profile runs to its end, then a quick off-on of the still
  // warm lamp must resume at the last step
  task automatic hot_restart;
    profile(0, OC_SEL_RESET, 7);
    check(step[0] === 3'h7, "profile did not stop");
    cmd[0] <= 1'b0;
    cyc(3);
    cmd[0] <= 1'b1;
    cyc(3);
    check(step[0] === 3'h6, "hot restart step");
  endtask : hot_restart
  //////////////////////////////////////////////////////////////////////////
  // main sequence; each scenario resets, so order does not matter
  initial begin
    reset_state();
    hot_restart();
    profile(1, 2'h1, 7);
    profile(2, 2'h2, 2);
    profile(3, 2'h3, 2);
    for (int k = 0; k < 4; k++) begin
      fault_case(k);
    end
    wdog();
    openload();
    finish_test();
  end
  // cut a hang short, well beyond the expected run
  initial begin
    #300000;
    bad_count++;
    finish_test();
  end
endmodule : overcurrent_profile_timer_tb_top
`default_nettype wire
